/* serial_ctrl_pkg.sv */
// Register map, field layout and types of the serial interface control
package serial_ctrl_pkg;
   // ==========================================================
   // Register byte addresses
   localparam logic [23:0] ADDR_PRIO = 24'h00FF20;
   localparam logic [23:0] ADDR_IEN = 24'h00FF23;
   localparam logic [23:0] ADDR_IFLAG = 24'h00FF27;
   localparam logic [23:0] ADDR_CONFIG = 24'h00FF48;
   localparam logic [23:0] ADDR_CTRL = 24'h00FF49;
   localparam logic [23:0] ADDR_DATA = 24'h00FF4A;
   localparam logic [23:0] ADDR_FORMAT = 24'h00FF4B;
   // ==========================================================
   // Field positions
   localparam int PRIO_LO = 4;
   localparam int PRIO_HI = 5;
   localparam int B_TRANSMIT_ENABLE = 0;
   localparam int B_TRANSMIT_TRIGGER = 1;
   localparam int B_RECEIVE_ENABLE = 2;
   localparam int B_RECEIVE_TRIGGER = 3;
   localparam int B_OER = 4;
   localparam int B_PER = 5;
   localparam int B_FER = 6;
   localparam int F_TX = 0;
   localparam int F_RX = 1;
   localparam int F_ERR = 2;
   localparam int B_ORDER = 0;
   localparam int B_STOP = 1;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_IRQ3 = 3'h0;
   localparam logic [1:0] RST_PRIO = 2'h0;
   // ==========================================================
   // Modes and clock sources
   typedef enum logic [1:0] {
      MODE_MASTER = 2'b00,
      MODE_SLAVE = 2'b01,
      MODE_ASYNC7 = 2'b10,
      MODE_ASYNC8 = 2'b11
   } xfer_mode_type;
   typedef enum logic [1:0] {
      SRC_DIV16 = 2'b00,
      SRC_DIV8 = 2'b01,
      SRC_DIV4 = 2'b10,
      SRC_TIMER = 2'b11
   } clk_src_type;
   // Configuration byte, bit 7 reads zero
   typedef struct packed {
      logic parity_enable;
      logic parity_sense;
      clk_src_type bit_clk_src;
      xfer_mode_type xfer_mode;
      logic serial_pin_select;
   } cfg_type;
endpackage : serial_ctrl_pkg

/* serial_interface_control.sv */
// Serial interface control: registers, bit clock, shifters, pins
//
// Summary of operation
// - Pin select 1 gives four shared pins to serial in/out/clock/ready.
// - Mode field: 11 async 8, 10 async 7, 01 sync slave, 00 master.
// - Clock source: 11 timer, 10 osc/4, 01 osc/8, 00 osc/16.
// - Sync slave ignores clock source, shifts on external clock.
// - Bit order 1 sends MSB first, 0 LSB first.
// - Async stop length 1 gives two stop bits, 0 one.
// - Sync modes add no start or stop bits.
// - Parity enable appends parity on send and checks it on receive.
// - Parity only works in async modes.
// - Parity sense 1 odd, 0 even, only while parity enabled.
// - Transmit enable bit enables or disables the transmitter.
// - Transmit trigger write 1 starts sending; reads busy status.
// - Receive enable bit enables or disables the receiver.
// - Sync receive trigger starts reception; slave ready goes low.
// - Async receive trigger empties buffer; late trigger means overrun.
// - Receive trigger reads busy status; writing 0 does nothing.
// - Data write loads transmit buffer; async 7-bit ignores top bit.
// - Priority field sets serial interrupt level 0 to 3.
// - Three enable bits gate error, receive, transmit interrupts.
// - Three factor flags set on events, cleared by writing 1.
// - Transmit flag on send end, receive flag on buffer load without overrun.
// - Request needs enable and priority above the CPU mask.
// - Error flag set on parity, framing or overrun error.
`timescale 1ns/1ps
`default_nettype none
module serial_interface_control
   import serial_ctrl_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic [23:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rd_data_o,
   input wire logic timer_tick_i,
   input wire logic [1:0] cpu_mask_i,
   input wire logic [3:0] pin_in_i,
   input wire logic [3:0] gpio_out_i,
   input wire logic [3:0] gpio_oe_i,
   output logic [3:0] pin_out_o,
   output logic [3:0] pin_oe_o,
   output logic irq_req_o,
   output logic [1:0] irq_level_o
);
   // ==========================================================
   // Helpers
   function automatic logic hit(input logic [23:0] a,
                                input logic [23:0] b);
      return a == b;
   endfunction : hit

   // Mirror a byte; 7-bit frames mirror only the low seven
   function automatic logic [7:0] order(input logic [7:0] d,
                                        input logic seven,
                                        input logic msb);
      logic [7:0] r;
      r = d;
      if (msb) begin
         for (int i = 0; i < 8; i++) begin
            r[i] = d[7 - i];
         end
         if (seven) begin
            r = {1'b0, r[7:1]};
         end
      end
      if (seven) begin
         r[7] = 1'b0;
      end
      return r;
   endfunction : order

   // ==========================================================
   // State
   cfg_type cfg;
   logic [1:0] prio;
   logic [2:0] ien, iflag;
   logic transmit_enable, receive_enable, tx_busy, rx_busy, rx_full;
   logic overrun_flag, per, fer, bit_order, stop2;
   logic [7:0] rx_buf;
   logic [11:0] txsr, rxsr;
   logic [3:0] div_cnt, tx_cnt, rx_cnt, sync_cnt;
   logic tx_ph, rx_ph, rx_hunt, sclk_q, sclk_d, serial_out_pin;
   logic [3:0] pin_meta, pin_s;

   // ==========================================================
   // Address decode
   wire logic wr_prio = wr_i && hit(addr_i, ADDR_PRIO);
   wire logic wr_ien = wr_i && hit(addr_i, ADDR_IEN);
   wire logic wr_flag = wr_i && hit(addr_i, ADDR_IFLAG);
   wire logic wr_cfg = wr_i && hit(addr_i, ADDR_CONFIG);
   wire logic wr_ctl = wr_i && hit(addr_i, ADDR_CTRL);
   wire logic wr_dat = wr_i && hit(addr_i, ADDR_DATA);
   wire logic wr_fmt = wr_i && hit(addr_i, ADDR_FORMAT);

   // Mode decode
   wire logic is_async = cfg.xfer_mode[1];
   wire logic is_7 = cfg.xfer_mode == MODE_ASYNC7;
   wire logic slave = cfg.xfer_mode == MODE_SLAVE;
   wire logic par_on = is_async && cfg.parity_enable;
   wire logic [3:0] nd = is_7 ? 4'd7 : 4'd8;
   // Start, data, parity, stops: sync frames carry only the data bits
   wire logic [3:0] flen = 4'd2 + nd + {3'b0, par_on}
      + {3'b0, stop2};
   wire logic serial_in_pin = pin_s[0];

   // ==========================================================
   // Bit clock enable from the fast clock or the timer
   wire logic clk_en = (cfg.bit_clk_src == SRC_TIMER) ? timer_tick_i :
      (cfg.bit_clk_src == SRC_DIV4) ? &div_cnt[1:0] :
      (cfg.bit_clk_src == SRC_DIV8) ? &div_cnt[2:0] : &div_cnt;

   // Sync edges: master makes its own clock, slave follows the pin
   wire logic sync_go = !is_async && (tx_busy || rx_busy);
   wire logic m_step = sync_go && !slave && clk_en;
   wire logic shift_edge = slave ? sync_go && sclk_d && !pin_s[2]
      : m_step && sclk_q;
   wire logic sample_edge = slave ? sync_go && !sclk_d && pin_s[2]
      : m_step && !sclk_q;
   wire logic sync_done = sample_edge && sync_cnt == 4'd7;

   // ==========================================================
   // Transmit frame build
   // Data written to the buffer is latched at the write; the frame is built at the trigger
   logic [7:0] tx_hold;
   wire logic [7:0] tx_src = wr_dat ? wr_data_i : tx_hold;
   wire logic [7:0] tx_ord = order(tx_src, is_7, bit_order);
   wire logic tx_par = ^tx_ord[6:0] ^ (!is_7 && tx_ord[7])
      ^ cfg.parity_sense;
   logic [11:0] tx_frame;
   always_comb begin
      tx_frame = {3'b111, tx_ord | {is_7, 7'h00}, 1'b0};
      if (par_on) begin
         tx_frame[nd + 4'd1] = tx_par;
      end
   end
   wire logic tx_start = wr_ctl && wr_data_i[B_TRANSMIT_TRIGGER]
      && wr_data_i[B_TRANSMIT_ENABLE] && !tx_busy
      && (is_async || !rx_busy);
   wire logic tx_bit_en = is_async && tx_busy && clk_en && tx_ph;
   wire logic tx_done = tx_busy && (is_async ?
      tx_bit_en && tx_cnt == flen : sync_done);

   // ==========================================================
   // Receive path
   wire logic rx_start = wr_ctl && wr_data_i[B_RECEIVE_TRIGGER]
      && wr_data_i[B_RECEIVE_ENABLE] && !rx_busy
      && (is_async || !tx_busy);
   wire logic rx_arm = wr_ctl && wr_data_i[B_RECEIVE_TRIGGER]
      && wr_data_i[B_RECEIVE_ENABLE];
   wire logic rx_samp = is_async && rx_busy && !rx_hunt
      && clk_en && rx_ph;
   wire logic rx_shift = rx_samp || (!is_async && rx_busy
      && sample_edge);
   wire logic [11:0] rx_nsr = {serial_in_pin, rxsr[11:1]};
   wire logic [11:0] aligned = rx_nsr >> (4'd12 - flen);
   wire logic a_done = rx_samp && rx_cnt == flen - 4'd1;
   wire logic rx_done = rx_busy && (is_async ? a_done : sync_done);
   wire logic [7:0] rx_word = is_async ? aligned[8:1] : rx_nsr[11:4];
   wire logic [7:0] rx_data = order(rx_word, is_7, bit_order);
   wire logic rx_pbit = aligned[nd + 4'd1];
   wire logic per_ev = a_done && par_on && (rx_pbit
      != (^rx_data ^ cfg.parity_sense));
   wire logic fer_ev = a_done && (!rx_nsr[11]
      || (stop2 && !rx_nsr[10]));
   wire logic oer_ev = a_done && rx_full;
   wire logic [2:0] ev = {per_ev || fer_ev || oer_ev,
      rx_done && !oer_ev, tx_done};

   // ==========================================================
   // Register writes, configuration
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cfg <= cfg_type'(RST_BYTE[6:0]);
         prio <= RST_PRIO;
         ien <= RST_IRQ3;
         bit_order <= 1'b0;
         stop2 <= 1'b0;
         transmit_enable <= 1'b0;
         receive_enable <= 1'b0;
      end else begin
         if (wr_cfg) cfg <= cfg_type'(wr_data_i[6:0]);
         if (wr_prio) prio <= wr_data_i[PRIO_HI:PRIO_LO];
         if (wr_ien) ien <= wr_data_i[2:0];
         if (wr_fmt) bit_order <= wr_data_i[B_ORDER];
         if (wr_fmt) stop2 <= wr_data_i[B_STOP];
         if (wr_ctl) transmit_enable <= wr_data_i[B_TRANSMIT_ENABLE];
         if (wr_ctl) receive_enable <= wr_data_i[B_RECEIVE_ENABLE];
      end
   end

   // Factor flags and receive errors: a set wins over a clear
   wire logic [2:0] fclr = wr_flag ? wr_data_i[2:0] : 3'b000;
   wire logic [2:0] eclr = wr_ctl ? wr_data_i[B_FER:B_OER] : 3'b000;
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         iflag <= RST_IRQ3;
         {fer, per, overrun_flag} <= RST_IRQ3;
      end else begin
         iflag <= (iflag & ~fclr) | ev;
         if (!receive_enable) {fer, per, overrun_flag} <= RST_IRQ3;
         else {fer, per, overrun_flag} <= ({fer, per, overrun_flag} & ~eclr)
            | {fer_ev, per_ev, oer_ev};
      end
   end

   // ==========================================================
   // Divider and pin synchronisers
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         div_cnt <= 4'h0;
         pin_meta <= 4'hF;
         pin_s <= 4'hF;
         sclk_d <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 4'd1;
         pin_meta <= pin_in_i;
         pin_s <= pin_meta;
         sclk_d <= pin_s[2];
      end
   end

   // ==========================================================
   // Transmitter; a cleared enable aborts the frame
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         tx_busy <= 1'b0;
         tx_hold <= RST_BYTE;
         txsr <= 12'hFFF;
         tx_cnt <= 4'h0;
         tx_ph <= 1'b0;
         serial_out_pin <= 1'b1;
      end else begin
         if (wr_dat) tx_hold <= wr_data_i;
         if (tx_start) begin
            tx_busy <= 1'b1;
            txsr <= is_async ? tx_frame : {4'hF, tx_ord};
            tx_cnt <= 4'h0;
            tx_ph <= 1'b1;
         end else if (!transmit_enable || tx_done) begin
            tx_busy <= 1'b0;
            serial_out_pin <= 1'b1;
         end else if (tx_bit_en || (!is_async && tx_busy
                      && shift_edge)) begin
            serial_out_pin <= txsr[0];
            txsr <= {1'b1, txsr[11:1]};
            tx_cnt <= tx_cnt + 4'd1;
         end
         if (tx_busy && is_async && clk_en) tx_ph <= !tx_ph;
      end
   end

   // ==========================================================
   // Receiver; async keeps running, sync stops after one byte
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rx_busy <= 1'b0;
         rx_full <= 1'b0;
         rx_hunt <= 1'b1;
         rx_ph <= 1'b0;
         rx_cnt <= 4'h0;
         rxsr <= 12'h000;
         rx_buf <= RST_BYTE;
      end else begin
         // The trigger may come in the same write that sets the enable
         if (rx_start) begin
            rx_busy <= 1'b1;
         end else if (!receive_enable || (!is_async && sync_done)) begin
            rx_busy <= 1'b0;
         end
         if (!receive_enable) rx_hunt <= 1'b1;
         rx_full <= receive_enable && ((rx_full && !rx_arm) || a_done);
         if (rx_shift) rxsr <= rx_nsr;
         if (rx_done) rx_buf <= rx_data;
         if (is_async && rx_busy && clk_en) begin
            if (rx_hunt) begin
               rx_hunt <= serial_in_pin;
               rx_ph <= 1'b1;
               rx_cnt <= 4'h0;
            end else begin
               rx_ph <= !rx_ph;
               if (rx_ph) begin
                  rx_hunt <= (rx_cnt == 4'h0 && serial_in_pin) || a_done;
                  rx_cnt <= rx_cnt + 4'd1;
               end
            end
         end
      end
   end

   // ==========================================================
   // Master clock and sync bit counter
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sclk_q <= 1'b1;
         sync_cnt <= 4'h0;
      end else begin
         sclk_q <= m_step ? !sclk_q : (sync_go ? sclk_q : 1'b1);
         if (!sync_go) sync_cnt <= 4'h0;
         else if (sample_edge) sync_cnt <= sync_cnt + 4'd1;
      end
   end

   // ==========================================================
   // Pin ownership; ready held low while a slave transfer is armed
   wire logic rdy = !(slave && (rx_busy || tx_busy));
   wire logic own = cfg.serial_pin_select;
   wire logic [3:0] ser_oe = {slave, !is_async && !slave, 2'b10};
   wire logic [3:0] ser_out = {rdy, sclk_q, serial_out_pin, 1'b1};
   wire logic [3:0] next_pin_out = own ? ser_out : gpio_out_i;
   wire logic [3:0] next_pin_oe = own ? ser_oe : gpio_oe_i;

   // Read mux; unmapped addresses read zero
   wire logic [7:0] next_rd =
      hit(addr_i, ADDR_PRIO) ? {2'b0, prio, 4'h0} :
      hit(addr_i, ADDR_IEN) ? {5'h00, ien} :
      hit(addr_i, ADDR_IFLAG) ? {5'h00, iflag} :
      hit(addr_i, ADDR_CONFIG) ? {1'b0, cfg} :
      hit(addr_i, ADDR_CTRL) ? {1'b0, fer, per, overrun_flag, rx_busy, receive_enable,
                                tx_busy, transmit_enable} :
      hit(addr_i, ADDR_DATA) ? rx_buf :
      hit(addr_i, ADDR_FORMAT) ? {6'h00, stop2, bit_order} : 8'h00;
   wire logic next_irq = |(iflag & ien) && prio > cpu_mask_i;

   // Outputs from flip-flops
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rd_data_o <= 8'h00;
         pin_out_o <= 4'h0;
         pin_oe_o <= 4'h0;
         irq_req_o <= 1'b0;
      end else begin
         rd_data_o <= rd_i ? next_rd : 8'h00;
         pin_out_o <= next_pin_out;
         pin_oe_o <= next_pin_oe;
         irq_req_o <= next_irq;
      end
   end
   assign irq_level_o = prio;

   // ==========================================================
   // Checks
   a_flag_set_wins: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i) tx_done |=> iflag[F_TX])
      else $error("transmit flag lost");
   a_overrun_noflag: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i) oer_ev && !iflag[F_RX]
      |=> iflag[F_ERR] && !iflag[F_RX] && overrun_flag)
      else $error("overrun handling wrong");
   a_irq_gate: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i) irq_req_o
      |-> $past(|(iflag & ien)) && $past(prio) > $past(cpu_mask_i))
      else $error("interrupt without cause");
   a_ready_low: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i) rx_start && slave && own
      && !wr_cfg |-> ##2 !pin_out_o[3])
      else $error("ready not low after trigger");
   a_pins_released: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i) !own |=> pin_oe_o == $past(gpio_oe_i))
      else $error("pins not returned to port");
   a_rx_errs_off: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i) !receive_enable |=> !overrun_flag && !per && !fer)
      else $error("errors held while receiver off");
   a_sync_no_par: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i) !is_async && !$past(is_async)
      |-> !$rose(per))
      else $error("parity error in sync mode");
   a_seven_top: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i) rx_done && is_7 |=> !rx_buf[7])
      else $error("top bit set in 7-bit mode");
   a_slave_noclk: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i) slave && own && !wr_cfg
      |=> ##1 !pin_oe_o[2])
      else $error("slave drives clock");
   a_tx_status: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i) tx_start |=> tx_busy)
      else $error("transmit status not set");
endmodule : serial_interface_control
`default_nettype wire

/* serial_far_end.sv */
// Far-side serial partner: drives the serial in line and the slave clock
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
   input wire logic ref_clk_i,
   input wire logic ready_n_i,
   output logic line_o,
   output logic sclk_o
);
   // ==========================================================
   // Line drivers
   // Both lines start high; send leaves the line high after a frame, clock_in leaves only the clock high
   initial begin
      line_o = 1'b1;
      sclk_o = 1'b1;
   end
   // Async frame, first bit first, each bit held for per cycles
   task automatic send(input logic [11:0] bits, input int nb, input int per);
      for (int k = 0; k < nb; k++) begin
         line_o <= bits[k];
         repeat (per) @(posedge ref_clk_i);
      end
      line_o <= 1'b1;
   endtask : send
   // Slave byte, LSB first; data moves while the clock is low
   task automatic clock_in(input logic [7:0] d, input int half,
                           output logic ok);
      int t;
      t = 0;
      // Bounded wait for ready, so a silent device cannot hang the run
      while (ready_n_i !== 1'b0 && t < 100) begin
         @(posedge ref_clk_i);
         t++;
      end
      ok = (t < 100);
      for (int k = 0; k < 8; k++) begin
         sclk_o <= 1'b0;
         line_o <= d[k];
         repeat (half) @(posedge ref_clk_i);
         sclk_o <= 1'b1;
         repeat (half) @(posedge ref_clk_i);
      end
      // Hold time over: show the inverse rather than a stale level
      line_o <= ~d[7];
   endtask : clock_in
endmodule : serial_far_end
`default_nettype wire

/* test_serial_interface_control.sv */
// Self-checking testbench of the serial interface control block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
   n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
   end end
module test_serial_interface_control import serial_ctrl_pkg::*;;
   // ==========================================================
   // Stimulus, wiring and instances
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [23:0] addr = '0;
   logic [7:0] wdata = '0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic rd_d = 1'b0;
   logic tick = 1'b0;
   logic [2:0] tcnt = '0;
   logic [1:0] mask = '0;
   logic [3:0] gout = '0;
   logic [3:0] goe = '0;
   logic [7:0] rdata;
   logic [3:0] pout, poe, pin;
   logic irq, line, sclk;
   logic [1:0] lvl;
   logic [15:0] e;
   logic [15:0] exp_q[$];
   int n_mismatch = 0;
   int compares = 0;
   int per[4] = '{32, 16, 8, 10};
   logic [23:0] amap[8] = '{ADDR_PRIO, ADDR_IEN, ADDR_IFLAG, ADDR_CONFIG,
      ADDR_CTRL, ADDR_DATA, ADDR_FORMAT, 24'h00FF21};
   always #5 clk = ~clk;
   // Timer pulse every 5 cycles, so a timer-clocked bit lasts 10
   always @(posedge clk) begin
      tcnt <= (tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
      tick <= (tcnt == 3'h4);
   end
   // Wire level: the device when it drives, else the partner or pull-up
   assign pin = (poe & pout) | (~poe & {1'b1, sclk, 1'b1, line});
   serial_interface_control dut (.ref_clk_i(clk), .sys_rst_i(rst),
      .addr_i(addr), .wr_data_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
      .rd_data_o(rdata), .timer_tick_i(tick), .cpu_mask_i(mask),
      .pin_in_i(pin), .gpio_out_i(gout), .gpio_oe_i(goe), .pin_out_o(pout),
      .pin_oe_o(poe), .irq_req_o(irq), .irq_level_o(lvl));
   serial_far_end far (.ref_clk_i(clk), .ready_n_i(pin[3]), .line_o(line),
      .sclk_o(sclk));
   // Read answers stand only one cycle after the strobe
   always @(posedge clk) begin
      if (rd_d) begin
         e = exp_q.pop_front();
         `CHECK("read data", e[7:0], rdata & e[15:8])
      end
      rd_d <= rd_s;
   end
   // ==========================================================
   // Bus and wait tasks
   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [23:0] a, input logic [7:0] d,
                     input logic [7:0] m = 8'hFF);
      exp_q.push_back({m, d & m});
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(posedge clk);
   endtask : rd
   // Settings only change with both directions disabled
   task automatic cfg(input logic pe, input logic ps, input clk_src_type s,
                      input xfer_mode_type m);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CONFIG, {1'b0, pe, ps, s, m, 1'b1});
   endtask : cfg
   task automatic wait_pin(input int k, input logic v);
      int t;
      t = 0;
      while (pout[k] !== v && t < 2000) begin
         @(posedge clk);
         t++;
      end
      if (t == 2000) begin
         n_mismatch++;
         $display("[FAIL] pin wait expected %h seen %h", v, pout[k]);
         test_done();
      end
   endtask : wait_pin
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   // ==========================================================
   // Main sequence
   initial begin
      logic [7:0] d;
      logic [11:0] f;
      logic par;
      logic ok;
      int nb, nd;
      void'($urandom(32'h7d883ff5));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (amap[k]) rd(amap[k], 8'h00);
      d = 8'($urandom());
      wr(ADDR_CONFIG, d & 8'h7E);
      rd(ADDR_CONFIG, d & 8'h7E);
      wr(ADDR_FORMAT, d);
      rd(ADDR_FORMAT, d & 8'h03);
      wr(ADDR_PRIO, 8'hFF);
      rd(ADDR_PRIO, 8'h30);
      `CHECK("level", 2'h3, lvl)
      wr(ADDR_IEN, 8'hFF);
      rd(ADDR_IEN, 8'h07);
      wr(ADDR_IFLAG, 8'hFF);
      rd(ADDR_IFLAG, 8'h00);
      gout <= 4'($urandom());
      goe <= 4'($urandom());
      repeat (3) @(posedge clk);
      `CHECK("gpio out", gout, pout)
      `CHECK("gpio oe", goe, poe)
      // Async transmit over every clock source, both lengths and orders
      for (int i = 0; i < 4; i++) begin
         mask <= 2'(i);
         cfg(i[1], i[0], clk_src_type'(i[1:0]),
             i[0] ? MODE_ASYNC8 : MODE_ASYNC7);
         wr(ADDR_FORMAT, {6'h00, i[1], i[0]});
         `CHECK("serial oe", 4'h2, poe)
         d = 8'($urandom());
         nd = i[0] ? 8 : 7;
         f = 12'hFFF;
         f[0] = 1'b0;
         for (int k = 0; k < nd; k++) f[k + 1] = i[0] ? d[7 - k] : d[k];
         par = (^(d & (i[0] ? 8'hFF : 8'h7F))) ^ i[0];
         if (i[1]) f[nd + 1] = par;
         nb = nd + 2 + 2 * i[1];
         wr(ADDR_DATA, d);
         wr(ADDR_CTRL, 8'h03);
         wait_pin(1, 1'b0);
         rd(ADDR_CTRL, 8'h03, 8'h03);
         repeat (per[i] / 2 - 2) @(posedge clk);
         for (int k = 0; k < nb; k++) begin
            `CHECK("tx bit", f[k], pout[1])
            repeat (per[i]) @(posedge clk);
         end
         rd(ADDR_IFLAG, 8'h01, 8'h01);
         `CHECK("irq", i < 3, irq)
         rd(ADDR_CTRL, 8'h01, 8'h03);
         wr(ADDR_IFLAG, 8'h01);
         rd(ADDR_IFLAG, 8'h00, 8'h01);
      end
      // Async receive: clean byte, overrun, then a parity error
      cfg(1'b1, 1'b0, SRC_DIV4, MODE_ASYNC8);
      wr(ADDR_FORMAT, 8'h00);
      wr(ADDR_CTRL, 8'h0C);
      rd(ADDR_CTRL, 8'h0C, 8'h0C);
      // Fourth frame carries a low stop bit: framing error
      for (int j = 0; j < 4; j++) begin
         d = 8'($urandom());
         far.send({1'b1, j != 3, (^d) ^ (j == 2), d, 1'b0}, 11, 8);
         repeat (8) @(posedge clk);
         rd(ADDR_IFLAG, j == 1 ? 8'h04 : j > 1 ? 8'h06 : 8'h02, 8'h07);
         rd(ADDR_CTRL, j == 0 ? 8'h00 : 8'(8'h08 << j), 8'h70);
         if (j != 1) rd(ADDR_DATA, d);
         wr(ADDR_IFLAG, 8'h07);
         if (j > 0) wr(ADDR_CTRL, 8'h7C);
      end
      // Sync slave receive; the clock source setting must not matter
      cfg(1'b0, 1'b0, clk_src_type'(2'($urandom())), MODE_SLAVE);
      wr(ADDR_CTRL, 8'h0C);
      repeat (2) @(posedge clk);
      `CHECK("ready", 2'b10, {poe[3], pout[3]})
      d = 8'($urandom());
      far.clock_in(d, 4, ok);
      `CHECK("ready seen", 1'b1, ok)
      if (ok !== 1'b1) test_done();
      repeat (6) @(posedge clk);
      rd(ADDR_CTRL, 8'h04, 8'h0C);
      rd(ADDR_DATA, d);
      rd(ADDR_IFLAG, 8'h02, 8'h07);
      // Sync master transmit: eight bare data bits, parity ignored
      cfg(1'b1, 1'b0, SRC_DIV4, MODE_MASTER);
      d = 8'($urandom());
      wr(ADDR_DATA, d);
      wr(ADDR_CTRL, 8'h03);
      for (int k = 0; k < 8; k++) begin
         wait_pin(2, 1'b0);
         wait_pin(2, 1'b1);
         `CHECK("sync bit", d[k], pout[1])
      end
      repeat (20) @(posedge clk);
      rd(ADDR_CTRL, 8'h01, 8'h03);
      `CHECK("master pins", 5'h16, {pout[2], poe})
      test_done();
   end
endmodule : test_serial_interface_control
`default_nettype wire
